// File: aig_gen.sv
// One inertial interrupt generator: axis compare, duration, mode, source flags.
// Assumes sample_tick is a one-cycle pulse per output data period.
module aig_gen
  import aig_pkg::*;
#(
  parameter int AXIS_W = 16
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                sample_tick,
  input  wire logic [3*AXIS_W-1:0] axis_data,
  input  wire logic [7:0]          cfg,
  input  wire logic [6:0]          ths,
  input  wire logic [6:0]          dur,
  input  wire logic                latch,
  input  wire logic                src_read,
  output logic      [6:0]          src_q
);

  if (AXIS_W < 9) begin : g_bad_width
    $error("aig_gen: AXIS_W must be at least 9");
  end

  logic [5:0]   raw_ev;
  logic [5:0]   en;
  logic [5:0]   ev;
  logic         six;
  aig_mode_type mode;
  logic         cond;
  logic         met;
  logic         act;
  logic [6:0]   cnt_q;
  logic         met_prev_q;

  assign en   = cfg[5:0];
  assign six  = cfg[CFG_SIXD_BIT];
  assign mode = aig_mode_type'({cfg[CFG_COMB_BIT], cfg[CFG_SIXD_BIT]});

  // Magnitude is saturated so the most negative sample does not wrap to zero.
  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic signed [AXIS_W-1:0] smp;
    logic        [AXIS_W-1:0] mag;
    logic        [6:0]        m7;
    assign smp = axis_data[i*AXIS_W +: AXIS_W];
    assign mag = smp[AXIS_W-1] ? AXIS_W'(-smp) : smp;
    assign m7  = mag[AXIS_W-1] ? 7'h7F : mag[AXIS_W-2 -: 7];
    // Six-direction modes use the sign to tell up from down.
    assign raw_ev[2*i+1] = six ? (!smp[AXIS_W-1] && (m7 > ths)) : (m7 > ths);
    assign raw_ev[2*i]   = six ? (smp[AXIS_W-1] && (m7 > ths)) : (m7 < ths);
  end

  always_comb begin
    ev = raw_ev & en;
    case (mode)
      MODE_AND: cond = (en != 6'h00) && ((ev | ~en) == 6'h3F);
      default:  cond = (ev != 6'h00);
    endcase
    met = cond && (cnt_q >= dur);
    case (mode)
      MODE_MOVE: act = met && !met_prev_q;
      default:   act = met;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= 7'h00;
      met_prev_q <= 1'b0;
    end else if (sample_tick) begin
      if (!cond) begin
        cnt_q <= 7'h00;
      end else if (cnt_q != 7'h7F) begin
        cnt_q <= 7'(cnt_q + 7'h01);
      end
      met_prev_q <= met;
    end
  end

  // A new event on the same edge as a read wins over the read's clear.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= 7'h00;
    end else if (sample_tick) begin
      if (!latch || !src_q[SRC_ACT_BIT]) begin
        src_q[5:0] <= act ? ev : 6'h00;
      end
      if (act) begin
        src_q[SRC_ACT_BIT] <= 1'b1;
      end else if (!latch || src_read) begin
        src_q[SRC_ACT_BIT] <= 1'b0;
      end
    end else if (src_read) begin
      src_q[SRC_ACT_BIT] <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  and_mode_block_a: assert property (
    sample_tick && mode == MODE_AND && !latch && ev != en |=> !src_q[SRC_ACT_BIT])
    else $error("AND mode raised with an enabled event missing");

  or_mode_raise_a: assert property (
    sample_tick && mode == MODE_OR && ev != 6'h00 && dur == 7'h00 |=> src_q[SRC_ACT_BIT])
    else $error("OR mode missed an enabled event");

  dur_block_a: assert property (
    sample_tick && cnt_q < dur && !latch |=> !src_q[SRC_ACT_BIT])
    else $error("event recognised before its duration");

  move_once_a: assert property (
    sample_tick && mode == MODE_MOVE && met_prev_q && !latch |=> !src_q[SRC_ACT_BIT])
    else $error("movement interrupt held beyond one period");

  pos_hold_a: assert property (
    sample_tick && mode == MODE_POS && met |=> src_q[SRC_ACT_BIT])
    else $error("position interrupt dropped inside a known zone");

  read_clear_a: assert property (
    src_read && !sample_tick |=> !src_q[SRC_ACT_BIT])
    else $error("source read did not clear the active flag");

  latch_hold_a: assert property (
    latch && src_q[SRC_ACT_BIT] && !src_read |=> $stable(src_q))
    else $error("latched source changed before it was read");

  flag_cause_a: assert property (
    $rose(src_q[SRC_ACT_BIT]) |-> $past(sample_tick) && $past(act))
    else $error("active flag set without a recognised event");

endmodule

// File: aig_host.sv
// Host processor model: a single-transfer AHB-Lite master for the register slave.
// Assumes hready is the slave's hreadyout and one core clock for all signals.
module aig_host
  import aig_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             hung
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hung = 1'b0;
  end

  // A slave that never answers would hang the run, so every wait is bounded.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) begin
      hung <= 1'b1;
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] wd,
                      output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= a;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata;
  endtask

  // Configuration is left alone until the boot-done status bit is seen.
  task automatic wait_boot();
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h0;
    while (r[ST_BOOT_BIT] !== 1'b1 && n < 20) begin
      xfer(1'b0, {22'h0, IDX_IRQ_STAT, 2'b00}, 8'h00, r);
      n++;
    end
    if (r[ST_BOOT_BIT] !== 1'b1) begin
      hung <= 1'b1;
    end
  endtask
endmodule

// File: aig_pkg.sv
// Shared constants for the inertial interrupt generator block.
// Assumes a single core clock; register indices map to byte address index*4.
package aig_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_CTRL     = 8'h24;
  localparam logic [7:0] IDX_G1_CFG   = 8'h30;
  localparam logic [7:0] IDX_G1_SRC   = 8'h31;
  localparam logic [7:0] IDX_G1_THS   = 8'h32;
  localparam logic [7:0] IDX_G1_DUR   = 8'h33;
  localparam logic [7:0] IDX_G2_CFG   = 8'h34;
  localparam logic [7:0] IDX_G2_SRC   = 8'h35;
  localparam logic [7:0] IDX_G2_THS   = 8'h36;
  localparam logic [7:0] IDX_G2_DUR   = 8'h37;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;

  // Field positions.
  localparam int CFG_COMB_BIT = 7;
  localparam int CFG_SIXD_BIT = 6;
  localparam int SRC_ACT_BIT  = 6;
  localparam int CTRL_BOOT    = 7;
  localparam int CTRL_LIR1    = 3;
  localparam int CTRL_LIR2    = 1;
  localparam int ST_G1_BIT    = 0;
  localparam int ST_G2_BIT    = 1;
  localparam int ST_BOOT_BIT  = 2;

  // Values after reset.
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [6:0] THS_RST  = 7'h00;
  localparam logic [6:0] DUR_RST  = 7'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] IRQ_RST  = 3'h0;

  // Core clock cycles spent reloading configuration at boot.
  localparam int BOOT_CYCLES_DEF = 16;

  typedef enum logic [1:0] {
    MODE_OR   = 2'b00,
    MODE_MOVE = 2'b01,
    MODE_AND  = 2'b10,
    MODE_POS  = 2'b11
  } aig_mode_type;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b01,
    ST_RUN  = 2'b10
  } aig_state_type;

endpackage

// File: aig_top.sv
// Inertial interrupt generators with an AHB-Lite register slave.
// Assumes one clock, synchronous inputs and a single-slave AHB-Lite bus.
module aig_top
  import aig_pkg::*;
#(
  parameter int         AXIS_W      = 16,
  parameter int         BOOT_CYCLES = BOOT_CYCLES_DEF,
  parameter logic [7:0] CFG1_BOOT   = 8'h00,
  parameter logic [7:0] CFG2_BOOT   = 8'h00
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                sample_rate_tick,
  input  wire logic [3*AXIS_W-1:0] axis_data,
  output logic                     irq_pin_one,
  output logic                     irq_pin_two,
  output logic                     irq
);

  if (BOOT_CYCLES < 1 || BOOT_CYCLES > 255) begin : g_bad_boot
    $error("aig_top: BOOT_CYCLES must lie in 1..255");
  end

  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic mapped(input logic [31:0] addr);
    logic [7:0] idx;
    idx = word_index(addr);
    mapped = (addr[31:10] == 22'h000000) &&
             ((idx >= IDX_G1_CFG && idx <= IDX_G2_DUR) || idx == IDX_CTRL ||
              idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK);
  endfunction

  localparam logic [7:0] BOOT_LAST = 8'(BOOT_CYCLES - 1);

  logic [7:0]    cfg1_q;
  logic [7:0]    cfg2_q;
  logic [6:0]    ths1_q;
  logic [6:0]    ths2_q;
  logic [6:0]    dur1_q;
  logic [6:0]    dur2_q;
  logic [7:0]    ctrl_q;
  logic [2:0]    irq_stat_q;
  logic [2:0]    irq_mask_q;
  aig_state_type st_q;
  logic [7:0]    boot_cnt_q;
  logic [7:0]    addr_q;
  logic          map_q;
  logic          wr_pend_q;
  logic          rd_pend_q;
  logic [31:0]   hrdata_q;
  logic          hreadyout_q;
  logic          hresp_q;
  logic          pin1_q;
  logic          pin2_q;
  logic          irq_q;
  logic [1:0]    act_prev_q;
  logic [6:0]    src1;
  logic [6:0]    src2;
  logic          accept;
  logic          wr_now;
  logic          boot_end;
  logic          src1_read;
  logic          src2_read;
  logic [2:0]    irq_set;
  logic [7:0]    wbyte;

  assign accept    = hsel && htrans[1] && hready;
  assign wr_now    = wr_pend_q && map_q;
  assign wbyte     = hwdata[7:0];
  assign boot_end  = (st_q == ST_BOOT) && (boot_cnt_q == BOOT_LAST);
  assign src1_read = rd_pend_q && map_q && addr_q == IDX_G1_SRC;
  assign src2_read = rd_pend_q && map_q && addr_q == IDX_G2_SRC;

  // Bus slave: writes complete with no wait state; reads take one wait state
  // so that read data and the read-clear side effect see any preceding write.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q      <= 8'h00;
      map_q       <= 1'b0;
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else if (rd_pend_q) begin
      rd_pend_q   <= 1'b0;
      hreadyout_q <= 1'b1;
    end else if (hready) begin
      wr_pend_q <= accept && hwrite;
      rd_pend_q <= accept && !hwrite;
      if (accept) begin
        addr_q      <= word_index(haddr);
        map_q       <= mapped(haddr);
        hreadyout_q <= hwrite;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata_q <= 32'h00000000;
      if (map_q) begin
        case (addr_q)
          IDX_CTRL:     hrdata_q[7:0] <= ctrl_q;
          IDX_G1_CFG:   hrdata_q[7:0] <= cfg1_q;
          IDX_G1_SRC:   hrdata_q[7:0] <= {1'b0, src1};
          IDX_G1_THS:   hrdata_q[7:0] <= {1'b0, ths1_q};
          IDX_G1_DUR:   hrdata_q[7:0] <= {1'b0, dur1_q};
          IDX_G2_CFG:   hrdata_q[7:0] <= cfg2_q;
          IDX_G2_SRC:   hrdata_q[7:0] <= {1'b0, src2};
          IDX_G2_THS:   hrdata_q[7:0] <= {1'b0, ths2_q};
          IDX_G2_DUR:   hrdata_q[7:0] <= {1'b0, dur2_q};
          IDX_IRQ_STAT: hrdata_q[2:0] <= irq_stat_q;
          IDX_IRQ_MASK: hrdata_q[2:0] <= irq_mask_q;
          default:      hrdata_q      <= 32'h00000000;
        endcase
      end
    end
  end

  // Boot sequence: after reset or a software request the configuration is
  // reloaded from the stored defaults, and bus writes to it are dropped.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= ST_BOOT;
      boot_cnt_q <= 8'h00;
    end else begin
      case (st_q)
        ST_BOOT: begin
          boot_cnt_q <= 8'(boot_cnt_q + 8'h01);
          if (boot_end) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          boot_cnt_q <= 8'h00;
          if (wr_now && addr_q == IDX_CTRL && wbyte[CTRL_BOOT]) begin
            st_q <= ST_BOOT;
          end
        end
        default: begin
          st_q       <= ST_BOOT;
          boot_cnt_q <= 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_q <= CFG_RST;
      cfg2_q <= CFG_RST;
    end else if (boot_end) begin
      cfg1_q <= CFG1_BOOT;
      cfg2_q <= CFG2_BOOT;
    end else if (wr_now && st_q == ST_RUN) begin
      if (addr_q == IDX_G1_CFG) begin
        cfg1_q <= wbyte;
      end
      if (addr_q == IDX_G2_CFG) begin
        cfg2_q <= wbyte;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ths1_q <= THS_RST;
      ths2_q <= THS_RST;
      dur1_q <= DUR_RST;
      dur2_q <= DUR_RST;
    end else if (wr_now) begin
      case (addr_q)
        IDX_G1_THS: ths1_q <= wbyte[6:0];
        IDX_G2_THS: ths2_q <= wbyte[6:0];
        IDX_G1_DUR: dur1_q <= wbyte[6:0];
        IDX_G2_DUR: dur2_q <= wbyte[6:0];
        default:    ths1_q <= ths1_q;
      endcase
    end
  end

  // The boot bit reads back high from a software boot request until the reload has finished.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_now && addr_q == IDX_CTRL) begin
        ctrl_q[CTRL_LIR1] <= wbyte[CTRL_LIR1];
        ctrl_q[CTRL_LIR2] <= wbyte[CTRL_LIR2];
      end
      if (boot_end) begin
        ctrl_q[CTRL_BOOT] <= 1'b0;
      end else if (wr_now && addr_q == IDX_CTRL && wbyte[CTRL_BOOT]) begin
        ctrl_q[CTRL_BOOT] <= 1'b1;
      end
    end
  end

  aig_gen #(
    .AXIS_W(AXIS_W)
  ) u_gen1 (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .sample_tick (sample_rate_tick),
    .axis_data   (axis_data),
    .cfg         (cfg1_q),
    .ths         (ths1_q),
    .dur         (dur1_q),
    .latch       (ctrl_q[CTRL_LIR1]),
    .src_read    (src1_read),
    .src_q       (src1)
  );

  aig_gen #(
    .AXIS_W(AXIS_W)
  ) u_gen2 (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .sample_tick (sample_rate_tick),
    .axis_data   (axis_data),
    .cfg         (cfg2_q),
    .ths         (ths2_q),
    .dur         (dur2_q),
    .latch       (ctrl_q[CTRL_LIR2]),
    .src_read    (src2_read),
    .src_q       (src2)
  );

  // Status bits record a rising active flag and the end of boot; a new event
  // in the same cycle as its write-one clear keeps the bit set.
  assign irq_set = {boot_end,
                    src2[SRC_ACT_BIT] && !act_prev_q[1],
                    src1[SRC_ACT_BIT] && !act_prev_q[0]};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= IRQ_RST;
      irq_mask_q <= IRQ_RST;
      act_prev_q <= 2'b00;
    end else begin
      act_prev_q <= {src2[SRC_ACT_BIT], src1[SRC_ACT_BIT]};
      if (wr_now && addr_q == IDX_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~wbyte[2:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      if (wr_now && addr_q == IDX_IRQ_MASK) begin
        irq_mask_q <= wbyte[2:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin1_q <= 1'b0;
      pin2_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      pin1_q <= src1[SRC_ACT_BIT];
      pin2_q <= src2[SRC_ACT_BIT];
      irq_q  <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign hrdata      = hrdata_q;
  assign hreadyout   = hreadyout_q;
  assign hresp       = hresp_q;
  assign irq_pin_one = pin1_q;
  assign irq_pin_two = pin2_q;
  assign irq         = irq_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  boot_load_a: assert property (
    boot_end |=> cfg1_q == CFG1_BOOT && cfg2_q == CFG2_BOOT && st_q == ST_RUN)
    else $error("boot did not reload the configuration");

  boot_write_a: assert property (
    st_q == ST_BOOT && !boot_end |=> $stable(cfg1_q) && $stable(cfg2_q))
    else $error("configuration changed during boot");

  src_read_a: assert property (
    rd_pend_q && map_q && addr_q == IDX_G1_SRC |=> hrdata_q == {25'h0, $past(src1)})
    else $error("source read returned the wrong value");

  pin_two_a: assert property (
    src2_read && !sample_rate_tick |=> ##1 !irq_pin_two)
    else $error("second pin still high after its source read");

  read_wait_a: assert property (
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not complete after one wait state");

endmodule

// File: tb_accel_inertial_interrupt_generators.sv
// Self-checking bench: the host model drives the bus, results are compared from a queue.
// Assumes the generator top with a short boot count and a nonzero boot image for gen1.
module tb_accel_inertial_interrupt_generators
  import aig_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        tick;
  logic [47:0] axis;
  logic        irq_pin_one;
  logic        irq_pin_two;
  logic        irq;
  logic        hung;
  logic        res_vld;
  logic [31:0] res_val;
  logic [31:0] d;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  string       nm_q[$];
  int          num_errors;
  int          comparisons;
  integer      seed;
  logic [6:0]  t;
  logic [15:0] hi;
  logic [15:0] lo;
  logic [15:0] eq;
  localparam logic [7:0] ZIDX [7] = '{IDX_G1_SRC, IDX_G1_THS, IDX_G1_DUR, IDX_G2_CFG,
                                      IDX_G2_SRC, IDX_G2_THS, IDX_G2_DUR};

  aig_top #(.AXIS_W(16), .BOOT_CYCLES(2), .CFG1_BOOT(8'h15), .CFG2_BOOT(8'h00)) u_aig_top (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_rate_tick(tick), .axis_data(axis),
    .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two), .irq(irq));

  aig_host u_aig_host (
    .core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (hung === 1'b1) begin
      num_errors++;
      give_verdict();
    end else if (res_vld === 1'b1) begin
      comparisons++;
      if ((res_val & msk_q[0]) !== exp_q[0]) begin
        num_errors++;
        $display("wrong value %s expected %h seen %h", nm_q[0], exp_q[0], res_val & msk_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
      void'(nm_q.pop_front());
    end
  end

  function automatic logic [31:0] ad(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction

  task automatic note(input string nm, input logic [31:0] e, input logic [31:0] m,
                      input logic [31:0] v);
    exp_q.push_back(e);
    msk_q.push_back(m);
    nm_q.push_back(nm);
    res_val <= v;
    res_vld <= 1'b1;
    @(posedge core_clk);
    res_vld <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    u_aig_host.xfer(1'b1, ad(idx), v, d);
  endtask

  task automatic rd(input string nm, input logic [31:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hFF);
    u_aig_host.xfer(1'b0, a, 8'h00, d);
    note(nm, {24'h0, e}, {24'hFFFFFF, m}, d);
  endtask

  task automatic pulse(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(posedge core_clk);
    axis <= {z, y, x};
    tick <= 1'b1;
    @(posedge core_clk);
    tick <= 1'b0;
  endtask

  // The interrupt output trails the source flags by two cycles, so look three edges on.
  task automatic pins(input logic [2:0] e);
    repeat (3) @(posedge core_clk);
    note("pins", {29'h0, e}, 32'hF, {28'h0, hresp, irq, irq_pin_two, irq_pin_one});
  endtask

  initial begin
    rst_n = 1'b0;
    tick = 1'b0;
    axis = 48'h0;
    res_vld = 1'b0;
    res_val = 32'h0;
    num_errors = 0;
    comparisons = 0;
    seed = 32'hcae9;
    t = 7'd8 + 7'($unsigned($random(seed)) % 48);
    hi = {1'b0, t + 7'd3, 8'h00};
    lo = {1'b0, t - 7'd3, 8'h00};
    eq = {1'b0, t, 8'h00};
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    u_aig_host.wait_boot();
    rd("gen1_config", ad(IDX_G1_CFG), 8'h15);
    for (int i = 0; i < 7; i++) begin
      rd("reset value", ad(ZIDX[i]), 8'h00);
    end
    rd("unmapped", 32'h400, 8'h00);
    wr(IDX_G1_THS, 8'hFF);
    rd("gen1_threshold", ad(IDX_G1_THS), 8'h7F);
    wr(IDX_G2_THS, 8'hFF);
    rd("gen2_threshold", ad(IDX_G2_THS), 8'h7F);
    wr(IDX_G1_THS, {1'b0, t});
    wr(IDX_G2_THS, {1'b0, t});
    // OR of all six enables; z equal to the threshold raises neither flag.
    wr(IDX_G1_CFG, 8'h3F);
    pulse(hi, lo, eq);
    pins(3'b001);
    rd("gen1_source", ad(IDX_G1_SRC), 8'h46);
    rd("gen1_source", ad(IDX_G1_SRC), 8'h06);
    pins(3'b000);
    rd("irq_stat", ad(IDX_IRQ_STAT), 8'h05);
    wr(IDX_IRQ_MASK, 8'h01);
    pins(3'b100);
    wr(IDX_IRQ_STAT, 8'h01);
    pins(3'b000);
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_G1_CFG, 8'h8A);
    pulse(hi, lo, eq);
    rd("and active", ad(IDX_G1_SRC), 8'h00, 8'h40);
    pulse(hi, hi, eq);
    rd("and active", ad(IDX_G1_SRC), 8'h40, 8'h40);
    wr(IDX_G1_DUR, 8'h02);
    wr(IDX_G1_CFG, 8'h02);
    pulse(lo, lo, eq);
    pulse(hi, lo, eq);
    pins(3'b000);
    pulse(hi, lo, eq);
    pins(3'b000);
    pulse(hi, lo, eq);
    pins(3'b001);
    wr(IDX_G1_DUR, 8'h00);
    wr(IDX_CTRL, 8'h08);
    pulse(hi, lo, eq);
    pulse(lo, lo, eq);
    rd("latched source", ad(IDX_G1_SRC), 8'h42, 8'h42);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_G1_CFG, 8'h42);
    pulse(hi, lo, eq);
    pins(3'b001);
    pulse(hi, lo, eq);
    pins(3'b000);
    wr(IDX_G1_CFG, 8'hC2);
    pulse(hi, lo, eq);
    pins(3'b001);
    pulse(hi, lo, eq);
    pins(3'b001);
    pulse(lo, lo, eq);
    pins(3'b000);
    wr(IDX_G1_CFG, 8'h00);
    wr(IDX_G2_CFG, 8'h02);
    pulse(hi, lo, eq);
    pins(3'b010);
    rd("gen2_source", ad(IDX_G2_SRC), 8'h42, 8'h42);
    pins(3'b000);
    // A software boot request must reload both configurations from the boot image.
    wr(IDX_CTRL, 8'h80);
    rd("gen1_config", ad(IDX_G1_CFG), 8'h15);
    rd("gen2_config", ad(IDX_G2_CFG), 8'h00);
    repeat (2) @(posedge core_clk);
    give_verdict();
  end
endmodule
